// [src/cbm_top.v]
`timescale 1ns/10ps
`include "cbm_defs.vh"

module cbm_top (
    input wire CORE_CLK, // 50 MHz system clock
    input wire RST_N, // async reset, active low
    input wire PSEL, // apb select
    input wire PENABLE, // apb enable
    input wire PWRITE, // apb direction
    input wire [`CBM_ADDR_W-1:0] PADDR, // apb byte address
    input wire [31:0] PWDATA, // apb write data
    output wire [31:0] PRDATA, // apb read data
    output wire PREADY, // apb ready
    output wire PSLVERR, // apb error
    input wire PWM_GEN1_LOW, // pwm sources
    input wire PWM_GEN1_HIGH, // pwm
    input wire PWM_GEN2_LOW, // pwm
    input wire PWM_GEN2_HIGH, // pwm
    input wire PWM_GEN3_LOW, // pwm
    input wire PWM_GEN3_HIGH, // pwm
    input wire TRIG_GEN_OUT_18, // trigger generator output
    input wire TRIG_GEN_OUT_19, // trigger generator output
    input wire FAULT_IN_2, // fault input
    input wire FAULT_IN_4, // fault input
    input wire CMP_RAW, // raw comparator output
    output wire MASK_A_SIGNAL, // selected mask A
    output wire MASK_B_SIGNAL, // selected mask B
    output wire AND_GATE_OUT, // and term result
    output wire CMP_GATED // comparator output after blanking
);
    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    reg [`CBM_REG_W-1:0] src_q;
    reg [`CBM_REG_W-1:0] gate_q;
    reg [31:0] rdata_q;
    reg err_q;
    wire hit_src = (PADDR == `CBM_OFF_MASK_SRC);
    wire hit_gate = (PADDR == `CBM_OFF_MASK_GATE);
    wire setup = PSEL && !PENABLE;
    wire acc = PSEL && PENABLE;

    // no wait states: read data and error registered in setup cycle
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            src_q <= `CBM_SRC_RST;
            gate_q <= `CBM_GATE_RST;
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            if (setup) begin
                err_q <= !(hit_src || hit_gate);
                if (hit_src) begin
                    rdata_q <= {16'h0000, src_q};
                end else if (hit_gate) begin
                    rdata_q <= {16'h0000, gate_q};
                end else begin
                    rdata_q <= 32'h0000_0000;
                end
            end
            if (acc && PWRITE && hit_src) begin
                src_q <= PWDATA[`CBM_REG_W-1:0] & `CBM_SRC_WMASK;
            end
            if (acc && PWRITE && hit_gate) begin
                gate_q <= PWDATA[`CBM_REG_W-1:0] & `CBM_GATE_WMASK;
            end
        end
    end
    assign PREADY = acc;
    assign PRDATA = rdata_q;
    assign PSLVERR = acc && err_q;

    // ----------------------------------------
    // input synchronisation
    // ----------------------------------------
    wire [10:0] raw_in = {CMP_RAW, FAULT_IN_4, FAULT_IN_2, TRIG_GEN_OUT_19, TRIG_GEN_OUT_18,
        PWM_GEN3_HIGH, PWM_GEN3_LOW, PWM_GEN2_HIGH, PWM_GEN2_LOW, PWM_GEN1_HIGH, PWM_GEN1_LOW};
    wire [10:0] syn_in;
    cbm_sync #(.WIDTH(11)) u_sync (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .d(raw_in),
        .q(syn_in)
    );

    // ----------------------------------------
    // mask selection
    // ----------------------------------------
    wire mask_a_signal;
    wire mask_b_signal;
    cbm_sel u_sel_a (
        .sel(src_q[`CBM_SELA_MSB:`CBM_SELA_LSB]),
        .src(syn_in[9:0]),
        .mask(mask_a_signal)
    );
    // mask B shares the code table; its field sits in the upper byte
    cbm_sel u_sel_b (
        .sel(src_q[`CBM_SELB_MSB:`CBM_SELB_LSB]),
        .src(syn_in[9:0]),
        .mask(mask_b_signal)
    );

    // ----------------------------------------
    // and gating
    // ----------------------------------------
    wire and_b_true_en = gate_q[`CBM_AND_B_TRUE_EN_BIT];
    wire and_b_inverted_en = gate_q[`CBM_AND_B_INVERTED_EN_BIT];
    wire and_a_true_en = gate_q[`CBM_AND_A_TRUE_EN_BIT];
    wire and_a_inverted_en = gate_q[`CBM_AND_A_INVERTED_EN_BIT];
    // disabled terms read as one so they cannot force a low
    wire and_d = (mask_b_signal | !and_b_true_en) // see R04
        & (!mask_b_signal | !and_b_inverted_en) // see R05
        & (mask_a_signal | !and_a_true_en) // see R06
        & (!mask_a_signal | !and_a_inverted_en); // see R07, see R08
    // all-disabled gives one; blanking then forces output low only when enabled
    wire any_en = |gate_q[`CBM_AND_B_TRUE_EN_BIT:`CBM_AND_A_INVERTED_EN_BIT];

    reg ma_q;
    reg mb_q;
    reg and_q;
    reg cmp_q;
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ma_q <= 1'b0;
            mb_q <= 1'b0;
            and_q <= 1'b1;
            cmp_q <= 1'b0;
        end else begin
            ma_q <= mask_a_signal;
            mb_q <= mask_b_signal;
            and_q <= and_d;
            cmp_q <= syn_in[10] & !(any_en & and_d);
        end
    end
    assign MASK_A_SIGNAL = ma_q;
    assign MASK_B_SIGNAL = mb_q;
    assign AND_GATE_OUT = and_q;
    assign CMP_GATED = cmp_q;
endmodule // cbm_top

// [src/cbm_defs.vh]
// Operation
// R01: mask-A selector codes 0000 to 0101 pick pwm generator 1 low, 1 high, 2 low, 2 high, 3 low, 3 high.
// R02: mask-A selector codes 1111, 1110, 1101, 1100 pick fault input 4, fault input 2, trigger output 19, 18.
// R03: mask-A selector codes 0110 to 1011 are reserved and select no source, giving a low mask-A signal.
// R04: gating bit 3 set connects the true mask-B signal to the and gate.
// R05: gating bit 2 set connects the inverted mask-B signal to the and gate.
// R06: gating bit 1 set connects the true mask-A signal to the and gate.
// R07: gating bit 0 set connects the inverted mask-A signal to the and gate.
// R08: the and gate output is the and of enabled terms only, disconnected terms counting as one.
`ifndef CBM_DEFS_VH
`define CBM_DEFS_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define CBM_ADDR_W 12
`define CBM_OFF_MASK_SRC 12'h000
`define CBM_OFF_MASK_GATE 12'h004
`define CBM_REG_W 16
`define CBM_SRC_RST 16'h0000
`define CBM_GATE_RST 16'h0000

// ----------------------------------------
// fields
// ----------------------------------------
`define CBM_SELA_LSB 0
`define CBM_SELA_MSB 3
`define CBM_SELB_LSB 8
`define CBM_SELB_MSB 11
`define CBM_SRC_WMASK 16'h0f0f
`define CBM_GATE_WMASK 16'h000f
`define CBM_AND_A_INVERTED_EN_BIT 0
`define CBM_AND_A_TRUE_EN_BIT 1
`define CBM_AND_B_INVERTED_EN_BIT 2
`define CBM_AND_B_TRUE_EN_BIT 3

// ----------------------------------------
// selector codes
// ----------------------------------------
`define CBM_SEL_PWM_GEN1_LOW 4'h0
`define CBM_SEL_PWM_GEN1_HIGH 4'h1
`define CBM_SEL_PWM_GEN2_LOW 4'h2
`define CBM_SEL_PWM_GEN2_HIGH 4'h3
`define CBM_SEL_PWM_GEN3_LOW 4'h4
`define CBM_SEL_PWM_GEN3_HIGH 4'h5
`define CBM_SEL_TRG18 4'hc
`define CBM_SEL_TRG19 4'hd
`define CBM_SEL_FAULT_IN_2 4'he
`define CBM_SEL_FAULT_IN_4 4'hf

`endif

// [src/cbm_sync.v]
`timescale 1ns/10ps
`include "cbm_defs.vh"

// three-stage synchroniser per bit; output moves when stages 2 and 3 agree
module cbm_sync #(
    parameter WIDTH = 10
) (
    input wire clk, // clock
    input wire rst_n, // async reset, active low
    input wire [WIDTH-1:0] d, // asynchronous inputs
    output wire [WIDTH-1:0] q // filtered outputs
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg out_q;
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    out_q <= 1'b0;
                end else begin
                    s1_q <= d[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        out_q <= s3_q;
                    end
                end
            end
            assign q[i] = out_q;
        end
    endgenerate
endmodule // cbm_sync

// [src/cbm_sel.v]
`timescale 1ns/10ps
`include "cbm_defs.vh"

// 16-way source selector shared by mask A and mask B
module cbm_sel (
    input wire [3:0] sel, // selector code
    input wire [9:0] src, // {fault_in_4,fault_in_2,trg19,trg18,p3h,p3l,p2h,p2l,p1h,p1l}
    output reg mask // selected mask signal
);
    always @* begin
        case (sel)
            `CBM_SEL_PWM_GEN1_LOW: mask = src[0]; // see R01
            `CBM_SEL_PWM_GEN1_HIGH: mask = src[1];
            `CBM_SEL_PWM_GEN2_LOW: mask = src[2];
            `CBM_SEL_PWM_GEN2_HIGH: mask = src[3];
            `CBM_SEL_PWM_GEN3_LOW: mask = src[4];
            `CBM_SEL_PWM_GEN3_HIGH: mask = src[5];
            `CBM_SEL_TRG18: mask = src[6]; // see R02
            `CBM_SEL_TRG19: mask = src[7];
            `CBM_SEL_FAULT_IN_2: mask = src[8];
            `CBM_SEL_FAULT_IN_4: mask = src[9];
            default: mask = 1'b0; // see R03
        endcase
    end
endmodule // cbm_sel

// [verification/cbm_chk_sva.sv]
`timescale 1ns/10ps
`include "cbm_defs.vh"
module cbm_chk (
    input wire CORE_CLK, // clk
    input wire RST_N, // rst
    input wire PSEL, // apb
    input wire PENABLE, // apb
    input wire PWRITE, // apb
    input wire [`CBM_ADDR_W-1:0] PADDR, // apb
    input wire [31:0] PWDATA, // apb
    input wire PWM_GEN1_LOW, // src
    input wire PWM_GEN1_HIGH, // src
    input wire PWM_GEN2_LOW, // src
    input wire PWM_GEN2_HIGH, // src
    input wire PWM_GEN3_LOW, // src
    input wire PWM_GEN3_HIGH, // src
    input wire TRIG_GEN_OUT_18, // src
    input wire TRIG_GEN_OUT_19, // src
    input wire FAULT_IN_2, // src
    input wire FAULT_IN_4, // src
    input wire MASK_A_SIGNAL, // out
    input wire MASK_B_SIGNAL, // out
    input wire AND_GATE_OUT // out
);
    wire [9:0] src = {FAULT_IN_4, FAULT_IN_2, TRIG_GEN_OUT_19, TRIG_GEN_OUT_18, PWM_GEN3_HIGH, PWM_GEN3_LOW,
        PWM_GEN2_HIGH, PWM_GEN2_LOW, PWM_GEN1_HIGH, PWM_GEN1_LOW};
    wire wr = PSEL && PENABLE && PWRITE;
    reg [3:0] sel_q, en_q, st_q;
    reg [9:0] src_q;
    // stability count: the sync path is slow, so judge only settled outputs
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sel_q <= 4'h0;
            en_q <= 4'h0;
            st_q <= 4'h0;
            src_q <= 10'h000;
        end else begin
            src_q <= src;
            if (wr && PADDR == `CBM_OFF_MASK_SRC) sel_q <= PWDATA[3:0];
            if (wr && PADDR == `CBM_OFF_MASK_GATE) en_q <= PWDATA[3:0];
            st_q <= (wr || src != src_q) ? 4'h0 : st_q + {3'h0, st_q != 4'hf};
        end
    end
    // the count restarts one edge late, so a fresh pin change must not slip through
    wire mr = st_q > 4'h7 && src == src_q;
    wire ar = st_q > 4'ha && src == src_q;
    wire ma = MASK_A_SIGNAL;
    wire mb = MASK_B_SIGNAL;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    sel_pwm_a: assert property (mr && sel_q < 4'h6 |-> ma == src[sel_q]) else $error("mask a pwm");
    sel_aux_a: assert property (mr && sel_q > 4'hb |-> ma == src[sel_q - 4'h6]) else $error("mask a aux");
    sel_rsvd_a: assert property (mr && sel_q inside {[6:11]} |-> !ma) else $error("mask a reserved");
    and_bt_a: assert property (ar && en_q[3] && !mb |-> !AND_GATE_OUT) else $error("and b true");
    and_bn_a: assert property (ar && en_q[2] && mb |-> !AND_GATE_OUT) else $error("and b inv");
    and_at_a: assert property (ar && en_q[1] && !ma |-> !AND_GATE_OUT) else $error("and a true");
    and_an_a: assert property (ar && en_q[0] && ma |-> !AND_GATE_OUT) else $error("and a inv");
    wire all_met = (!en_q[3] || mb) && (!en_q[2] || !mb) && (!en_q[1] || ma) && (!en_q[0] || !ma);
    and_all_a: assert property (ar && all_met |-> AND_GATE_OUT) else $error("and term low");
endmodule // cbm_chk
bind cbm_top cbm_chk i_cbm_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PWM_GEN1_LOW(PWM_GEN1_LOW), .PWM_GEN1_HIGH(PWM_GEN1_HIGH),
    .PWM_GEN2_LOW(PWM_GEN2_LOW), .PWM_GEN2_HIGH(PWM_GEN2_HIGH), .PWM_GEN3_LOW(PWM_GEN3_LOW),
    .PWM_GEN3_HIGH(PWM_GEN3_HIGH), .TRIG_GEN_OUT_18(TRIG_GEN_OUT_18), .TRIG_GEN_OUT_19(TRIG_GEN_OUT_19),
    .FAULT_IN_2(FAULT_IN_2), .FAULT_IN_4(FAULT_IN_4), .MASK_A_SIGNAL(MASK_A_SIGNAL),
    .MASK_B_SIGNAL(MASK_B_SIGNAL), .AND_GATE_OUT(AND_GATE_OUT));

// [verification/tb.sv]
`timescale 1ns/10ps
`include "cbm_defs.vh"
module tb;
    reg clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, raw = 0, ea, eb, ex;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, d;
    reg [9:0] src = 10'h000;
    reg [3:0] en;
    reg [32:0] q[$];
    reg [3:0] lq[$];
    reg [3:0] lv;
    wire [31:0] prdata;
    wire pready, pslverr, ma, mb, ag, cg;
    integer errors = 0, check_count = 0, seed = 31723, cyc = 0, i;
    cbm_top i_cbm_top (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PWM_GEN1_LOW(src[0]), .PWM_GEN1_HIGH(src[1]), .PWM_GEN2_LOW(src[2]), .PWM_GEN2_HIGH(src[3]),
        .PWM_GEN3_LOW(src[4]), .PWM_GEN3_HIGH(src[5]), .TRIG_GEN_OUT_18(src[6]), .TRIG_GEN_OUT_19(src[7]),
        .FAULT_IN_2(src[8]), .FAULT_IN_4(src[9]), .CMP_RAW(raw), .MASK_A_SIGNAL(ma), .MASK_B_SIGNAL(mb),
        .AND_GATE_OUT(ag), .CMP_GATED(cg));
    initial forever #10 clk = ~clk;
    task conclude;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task cmp(input [32:0] got, input [32:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task cmp_lvl(input got, input exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t level got %b want %b", $time, got, exp);
        end
    endtask
    // expected note: {error, read data}; writes carry zero data
    task apb(input w, input [11:0] a, input [31:0] dd, input [32:0] e);
        q.push_back(e);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dd;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 0;
        penable <= 0;
    endtask
    function mval(input [3:0] c);
        mval = c < 6 ? src[c] : c > 11 ? src[c - 6] : 1'b0;
    endfunction
    always @(posedge clk) if (psel && penable && pready === 1'b1) cmp({pslverr, pwrite ? 32'h0 : prdata}, q.pop_front());
    // level notes {mask a, mask b, and term, gated}; judged only once the outputs have settled
    always @(posedge clk) begin
        if (lq.size() > 0) begin
            lv = lq.pop_front();
            cmp_lvl(ma, lv[3]);
            cmp_lvl(mb, lv[2]);
            cmp_lvl(ag, lv[1]);
            cmp_lvl(cg, lv[0]);
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            conclude;
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1;
        apb(0, `CBM_OFF_MASK_SRC, 0, {17'h0, `CBM_SRC_RST});
        apb(0, `CBM_OFF_MASK_GATE, 0, {17'h0, `CBM_GATE_RST});
        d = $random(seed);
        apb(1, `CBM_OFF_MASK_SRC, d, 0);
        apb(1, 12'h008, ~d, {1'b1, 32'h0});
        apb(0, 12'h008, 0, {1'b1, 32'h0});
        apb(0, `CBM_OFF_MASK_SRC, 0, {17'h0, d[15:0] & `CBM_SRC_WMASK});
        apb(1, `CBM_OFF_MASK_GATE, d, 0);
        apb(0, `CBM_OFF_MASK_GATE, 0, {17'h0, d[15:0] & `CBM_GATE_WMASK});
        // every selector code and every enable pattern
        for (i = 0; i < 48; i++) begin
            en = 4'(i / 3);
            apb(1, `CBM_OFF_MASK_SRC, {20'h0, ~i[3:0], 4'h0, i[3:0]}, 0);
            apb(1, `CBM_OFF_MASK_GATE, {28'h0, en}, 0);
            d = $random(seed);
            src <= d[9:0];
            raw <= d[10];
            repeat (12) @(posedge clk);
            ea = mval(i[3:0]);
            eb = mval(~i[3:0]);
            ex = (!en[3] | eb) & (!en[2] | !eb) & (!en[1] | ea) & (!en[0] | !ea);
            lq.push_back({ea, eb, ex, raw & ~(|en & ex)});
        end
        // mid-run reset: levels fall back at once, registers read as after power-up
        repeat (2) @(posedge clk);
        rst_n <= 0;
        @(posedge clk);
        lq.push_back(4'h2);
        repeat (2) @(posedge clk);
        rst_n <= 1;
        apb(0, `CBM_OFF_MASK_SRC, 0, {17'h0, `CBM_SRC_RST});
        apb(0, `CBM_OFF_MASK_GATE, 0, {17'h0, `CBM_GATE_RST});
        // let the monitor take the last answer before the run ends
        @(posedge clk);
        conclude;
    end
endmodule // tb
